// ---- hw/slei_pkg.sv ----
// Constants, register map and lookup tables for the stereo level, EQ and image adjust stage
package slei_pkg;

  // ----------------------------------------------------------------
  // Register map (byte offsets, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [5:0] REG_MASTER = 6'h00;
  localparam logic [5:0] REG_PAN = 6'h04;
  localparam logic [5:0] REG_LOW_SHELF = 6'h08;
  localparam logic [5:0] REG_LOW_XO = 6'h0c;
  localparam logic [5:0] REG_SPATIAL = 6'h10;
  localparam logic [5:0] REG_HIGH_XO = 6'h14;
  localparam logic [5:0] REG_LEFT_HS = 6'h18;
  localparam logic [5:0] REG_RIGHT_HS = 6'h1c;
  localparam logic [5:0] REG_SPIN = 6'h20;
  localparam logic [5:0] REG_STATUS = 6'h24;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MASTER_RST = 8'h30;   // 0 dB
  localparam logic [5:0] SHELF_RST = 6'h0c;    // 0 dB
  localparam logic [15:0] XO_RST = 16'h1000;   // One-pole coefficient, Q16
  localparam logic [7:0] CODE_RST = 8'h00;     // Centre / off

  // ----------------------------------------------------------------
  // Master level code layout (attenuation counted in quarter dB from +12 dB)
  // ----------------------------------------------------------------
  localparam logic [7:0] MASTER_FINE_END = 8'h60;  // -12 dB, quarter dB below here
  localparam logic [7:0] MASTER_HALF_END = 8'hc0;  // -60 dB, half dB below here
  localparam logic [7:0] MASTER_MUTE = 8'hc6;      // -72 dB, output forced to zero
  localparam logic [8:0] ATT_HALF_BASE = 9'h060;
  localparam logic [8:0] ATT_COARSE_BASE = 9'h120;

  // Shelf codes: half dB steps, code 0 is +6 dB, code 48 is -18 dB
  localparam logic [5:0] SHELF_MAX = 6'h30;
  localparam logic [8:0] SHELF_ATT_OFS = 9'h018;

  // Crossfeed codes: signed, end stops at +-24
  localparam logic [7:0] CF_MAX = 8'h18;
  localparam logic [16:0] CF_STEP = 17'h00555;
  localparam logic [16:0] UNITY_Q15 = 17'h08000;

  // Pan and spin codes: signed, end stops at +-16
  localparam logic [7:0] ANGLE_MAX = 8'h10;
  localparam logic [5:0] QUARTER_IDX = 6'h20;

  // ----------------------------------------------------------------
  // Gain arithmetic
  // ----------------------------------------------------------------
  localparam logic [20:0] GAIN_ONE = 21'h010000;   // 1.0 in Q16
  localparam logic [16:0] STEP_2DB = 17'h0cb59;    // -2 dB in Q16

  // +12 dB down to +10.25 dB in quarter dB, Q16
  localparam logic [19:0] BASE_TAB [0:7] = '{
    20'h3fb27, 20'h3de3d, 20'h3c224, 20'h3a6d8,
    20'h38c52, 20'h3728d, 20'h35983, 20'h3412e};

  // Sine over a quarter turn in 32 steps, Q15
  localparam logic [16:0] SIN_TAB [0:32] = '{
    17'h00000, 17'h00648, 17'h00c8c, 17'h012c8, 17'h018f9, 17'h01f1a, 17'h02528,
    17'h02b1f, 17'h030fc, 17'h036ba, 17'h03c57, 17'h041ce, 17'h0471d, 17'h04c40,
    17'h05134, 17'h055f6, 17'h05a82, 17'h05ed7, 17'h062f2, 17'h066d0, 17'h06a6e,
    17'h06dca, 17'h070e3, 17'h073b6, 17'h07642, 17'h07885, 17'h07a7d, 17'h07c29,
    17'h07d8a, 17'h07e9d, 17'h07f62, 17'h07fd9, 17'h08000};

  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_GLOAD = 4'b0001,
    ST_GMUL = 4'b0010,
    ST_FILT = 4'b0011,
    ST_EQ = 4'b0100,
    ST_PAN = 4'b0101,
    ST_ROT = 4'b0110,
    ST_OUT = 4'b0111
  } slei_state_e;

endpackage

// ---- hw/slei_core.sv ----
// Stereo level, shelving EQ, crossfeed, balance and image rotate stage with Avalon-MM registers
module slei_core
  import slei_pkg::*;
#(
  parameter int SAMPLE_W = 24
) (
  input wire logic ref_clk,                          // 125 MHz system clock
  input wire logic srst,                             // Synchronous reset, active high
  input wire logic [5:0] avs_address,                // Byte address of register
  input wire logic avs_read,                         // Read request
  input wire logic avs_write,                        // Write request
  input wire logic [31:0] avs_writedata,             // Write data
  output logic [31:0] avs_readdata,                  // Read data
  output logic avs_waitrequest,                      // Stall, low for one answer cycle
  input wire logic in_valid,                         // Input sample pair valid
  input wire logic signed [SAMPLE_W-1:0] in_left,    // Left input sample
  input wire logic signed [SAMPLE_W-1:0] in_right,   // Right input sample
  output logic in_ready,                             // Stage can take a pair
  output logic out_valid,                            // Output pair valid, one cycle
  output logic signed [SAMPLE_W-1:0] out_left,       // Left output sample
  output logic signed [SAMPLE_W-1:0] out_right       // Right output sample
);
  localparam int PW = SAMPLE_W + 24;
  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // One-pole low-pass step; coefficient below one keeps the state in range
  function automatic logic signed [SAMPLE_W-1:0] lp_step(
    input logic signed [SAMPLE_W-1:0] x,
    input logic signed [SAMPLE_W-1:0] st,
    input logic [15:0] a);
    logic signed [SAMPLE_W:0] d;
    logic signed [SAMPLE_W+17:0] p;
    d = (SAMPLE_W+1)'(x) - (SAMPLE_W+1)'(st);
    p = d * $signed({1'b0, a});
    return st + SAMPLE_W'(p >>> 16);
  endfunction
  // Cosine and sine of code * pi/64, code clamped to an eighth turn either way
  function automatic logic [35:0] trig_pair(input logic [7:0] code);
    logic [7:0] m;
    logic [5:0] k;
    logic [17:0] c;
    logic [17:0] s;
    m = code[7] ? 8'(-code) : code;
    k = (m > ANGLE_MAX) ? ANGLE_MAX[5:0] : m[5:0];
    c = {1'b0, SIN_TAB[QUARTER_IDX - k]};
    s = {1'b0, SIN_TAB[k]};
    if (code[7]) begin
      s = 18'(-s);
    end
    return {c, s};
  endfunction
  // Saturate a wide value to the sample width
  function automatic logic signed [SAMPLE_W-1:0] sat_w(input logic signed [PW-1:0] v);
    logic [PW-SAMPLE_W:0] top;
    top = v[PW-1:SAMPLE_W-1];
    if ((top == '0) || (top == '1)) begin
      return v[SAMPLE_W-1:0];
    end
    return v[PW-1] ? {1'b1, {(SAMPLE_W-1){1'b0}}} : {1'b0, {(SAMPLE_W-1){1'b1}}};
  endfunction
  // Attenuation of a shelf code in quarter dB from +12 dB, half dB per code
  function automatic logic [8:0] shelf_att(input logic [5:0] code);
    logic [5:0] c;
    c = (code > SHELF_MAX) ? SHELF_MAX : code;
    return SHELF_ATT_OFS + {2'b00, c, 1'b0};
  endfunction

  // ----------------------------------------------------------------
  // Software registers and bus slave
  // ----------------------------------------------------------------
  logic [7:0] master_level_q;
  logic [7:0] lr_pan_law_q;
  logic [5:0] low_shelf_gain_q;
  logic [15:0] low_crossover_freq_q;
  logic [7:0] spatial_crossfeed_q;
  logic [15:0] high_crossover_freq_q;
  logic [5:0] left_high_shelf_gain_q;
  logic [5:0] right_high_shelf_gain_q;
  logic [7:0] image_spin_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [15:0] pair_cnt_q;
  logic muted_q;
  slei_state_e state_q;
  slei_state_e state_d;
  // Answer one cycle after the request; the write lands on the answering edge
  wire bus_req = avs_read | avs_write;
  wire bus_take = bus_req & wait_q;
  wire wr_en = avs_write & ~wait_q;
  wire busy = (state_q != ST_IDLE);
  wire [31:0] status_word = {14'h0000, muted_q, busy, pair_cnt_q};
  wire [31:0] rd_mux =
    (avs_address == REG_MASTER) ? {24'h000000, master_level_q} :
    (avs_address == REG_PAN) ? {24'h000000, lr_pan_law_q} :
    (avs_address == REG_LOW_SHELF) ? {26'h0000000, low_shelf_gain_q} :
    (avs_address == REG_LOW_XO) ? {16'h0000, low_crossover_freq_q} :
    (avs_address == REG_SPATIAL) ? {24'h000000, spatial_crossfeed_q} :
    (avs_address == REG_HIGH_XO) ? {16'h0000, high_crossover_freq_q} :
    (avs_address == REG_LEFT_HS) ? {26'h0000000, left_high_shelf_gain_q} :
    (avs_address == REG_RIGHT_HS) ? {26'h0000000, right_high_shelf_gain_q} :
    (avs_address == REG_SPIN) ? {24'h000000, image_spin_q} :
    (avs_address == REG_STATUS) ? status_word : 32'h00000000;
  // Handshake and read data
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      wait_q <= ~bus_take;
      if (bus_take & avs_read) begin
        rdata_q <= rd_mux;
      end
    end
  end
  // Setting registers; unmapped writes are dropped
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      master_level_q <= MASTER_RST;
      lr_pan_law_q <= CODE_RST;
      low_shelf_gain_q <= SHELF_RST;
      low_crossover_freq_q <= XO_RST;
      spatial_crossfeed_q <= CODE_RST;
      high_crossover_freq_q <= XO_RST;
      left_high_shelf_gain_q <= SHELF_RST;
      right_high_shelf_gain_q <= SHELF_RST;
      image_spin_q <= CODE_RST;
    end else if (wr_en) begin
      if (avs_address == REG_MASTER) master_level_q <= avs_writedata[7:0];
      if (avs_address == REG_PAN) lr_pan_law_q <= avs_writedata[7:0];
      if (avs_address == REG_LOW_SHELF) low_shelf_gain_q <= avs_writedata[5:0];
      if (avs_address == REG_LOW_XO) low_crossover_freq_q <= avs_writedata[15:0];
      if (avs_address == REG_SPATIAL) spatial_crossfeed_q <= avs_writedata[7:0];
      if (avs_address == REG_HIGH_XO) high_crossover_freq_q <= avs_writedata[15:0];
      if (avs_address == REG_LEFT_HS) left_high_shelf_gain_q <= avs_writedata[5:0];
      if (avs_address == REG_RIGHT_HS) right_high_shelf_gain_q <= avs_writedata[5:0];
      if (avs_address == REG_SPIN) image_spin_q <= avs_writedata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Per-sample snapshot of settings
  // ----------------------------------------------------------------
  // Settings are frozen while a pair is in flight, so a write never splits a sample
  logic [7:0] s_master_q;
  logic [7:0] s_pan_q;
  logic [5:0] s_low_q;
  logic [15:0] s_lxo_q;
  logic [7:0] s_cf_q;
  logic [15:0] s_hxo_q;
  logic [5:0] s_hl_q;
  logic [5:0] s_hr_q;
  logic [7:0] s_spin_q;
  logic signed [SAMPLE_W-1:0] x_l_q;
  logic signed [SAMPLE_W-1:0] x_r_q;
  wire take_pair = in_valid & in_ready;

  always_ff @(posedge ref_clk) begin
    if (take_pair) begin
      s_master_q <= master_level_q;
      s_pan_q <= lr_pan_law_q;
      s_low_q <= low_shelf_gain_q;
      s_lxo_q <= low_crossover_freq_q;
      s_cf_q <= spatial_crossfeed_q;
      s_hxo_q <= high_crossover_freq_q;
      s_hl_q <= left_high_shelf_gain_q;
      s_hr_q <= right_high_shelf_gain_q;
      s_spin_q <= image_spin_q;
      x_l_q <= in_left;
      x_r_q <= in_right;
    end
  end

  // ----------------------------------------------------------------
  // Decibel to linear gain sequencer
  // ----------------------------------------------------------------
  // One shared multiplier steps -2 dB per cycle; trades latency for area
  logic [1:0] gi_q;
  logic [5:0] h_q;
  logic [19:0] acc_q;
  logic [19:0] gain_q [0:3];
  wire m_fine = (s_master_q <= MASTER_FINE_END);
  wire m_half = (s_master_q <= MASTER_HALF_END);
  wire m_mute = (s_master_q >= MASTER_MUTE);
  wire [8:0] m_att = m_fine ? {1'b0, s_master_q} :
    m_half ? ATT_HALF_BASE + {s_master_q - MASTER_FINE_END, 1'b0} :
    9'(ATT_COARSE_BASE + {s_master_q - MASTER_HALF_END, 3'b000});
  wire [8:0] att_sel = (gi_q == 2'd0) ? m_att :
    (gi_q == 2'd1) ? shelf_att(s_low_q) :
    (gi_q == 2'd2) ? shelf_att(s_hl_q) : shelf_att(s_hr_q);
  wire [36:0] acc_prod = acc_q * STEP_2DB + 37'h0008000;  // Rounded, so low gains keep their accuracy
  wire gain_done = (state_q == ST_GMUL) && (h_q == 6'h00);

  always_ff @(posedge ref_clk) begin
    if (state_q == ST_IDLE) begin
      gi_q <= 2'd0;
    end else if (state_q == ST_GLOAD) begin
      acc_q <= BASE_TAB[att_sel[2:0]];
      h_q <= att_sel[8:3];
    end else if (gain_done) begin
      gain_q[gi_q] <= (gi_q == 2'd0 && m_mute) ? 20'h00000 : acc_q;
      gi_q <= gi_q + 2'd1;
    end else if (state_q == ST_GMUL) begin
      acc_q <= acc_prod[35:16];
      h_q <= h_q - 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // Shelf and crossfeed filters
  // ----------------------------------------------------------------
  logic signed [SAMPLE_W-1:0] lo_l_q;
  logic signed [SAMPLE_W-1:0] lo_r_q;
  logic signed [SAMPLE_W-1:0] hi_l_q;
  logic signed [SAMPLE_W-1:0] hi_r_q;
  // One-pole states, one update per pair
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lo_l_q <= '0;
      lo_r_q <= '0;
      hi_l_q <= '0;
      hi_r_q <= '0;
    end else if (state_q == ST_FILT) begin
      lo_l_q <= lp_step(x_l_q, lo_l_q, s_lxo_q);
      lo_r_q <= lp_step(x_r_q, lo_r_q, s_lxo_q);
      hi_l_q <= lp_step(x_l_q, hi_l_q, s_hxo_q);
      hi_r_q <= lp_step(x_r_q, hi_r_q, s_hxo_q);
    end
  end

  // Shelf: x + (g-1)*lowpart for bass, x + (g-1)*highpart for treble
  wire signed [20:0] g_low_m1 = $signed({1'b0, gain_q[1]}) - $signed(GAIN_ONE);
  wire signed [20:0] g_hl_m1 = $signed({1'b0, gain_q[2]}) - $signed(GAIN_ONE);
  wire signed [20:0] g_hr_m1 = $signed({1'b0, gain_q[3]}) - $signed(GAIN_ONE);
  wire signed [SAMPLE_W:0] hp_l = (SAMPLE_W+1)'(x_l_q) - (SAMPLE_W+1)'(hi_l_q);
  wire signed [SAMPLE_W:0] hp_r = (SAMPLE_W+1)'(x_r_q) - (SAMPLE_W+1)'(hi_r_q);
  wire signed [SAMPLE_W+20:0] bass_l = g_low_m1 * lo_l_q;
  wire signed [SAMPLE_W+20:0] bass_r = g_low_m1 * lo_r_q;
  wire signed [SAMPLE_W+21:0] treb_l = g_hl_m1 * hp_l;
  wire signed [SAMPLE_W+21:0] treb_r = g_hr_m1 * hp_r;

  // Crossfeed: linear magnitude, exact unity at the end stops
  wire [7:0] cf_abs = s_cf_q[7] ? 8'(-s_cf_q) : s_cf_q;
  wire [16:0] cf_mag = (cf_abs >= CF_MAX) ? UNITY_Q15 :
    17'(cf_abs * CF_STEP);
  wire signed [SAMPLE_W+17:0] cf_from_r = $signed({1'b0, cf_mag}) * lo_r_q;
  wire signed [SAMPLE_W+17:0] cf_from_l = $signed({1'b0, cf_mag}) * lo_l_q;
  wire signed [PW-1:0] cf_l = PW'(cf_from_r >>> 15);
  wire signed [PW-1:0] cf_r = PW'(cf_from_l >>> 15);
  // Positive setting subtracts the opposite bass, so full scale cancels mono bass
  wire signed [PW-1:0] eq_l_w = PW'(x_l_q) + PW'(bass_l >>> 16) + PW'(treb_l >>> 16) +
    (s_cf_q[7] ? cf_l : -cf_l);
  wire signed [PW-1:0] eq_r_w = PW'(x_r_q) + PW'(bass_r >>> 16) + PW'(treb_r >>> 16) +
    (s_cf_q[7] ? cf_r : -cf_r);

  // ----------------------------------------------------------------
  // Balance, rotate and master level
  // ----------------------------------------------------------------
  logic signed [PW-1:0] eq_l_q;
  logic signed [PW-1:0] eq_r_q;
  logic signed [PW-1:0] pan_l_q;
  logic signed [PW-1:0] pan_r_q;
  logic signed [PW-1:0] rot_l_q;
  logic signed [PW-1:0] rot_r_q;
  wire [35:0] pan_cs = trig_pair(s_pan_q);
  wire [35:0] spin_cs = trig_pair(s_spin_q);
  // sqrt2*cos(theta) = cos(phi) - sin(phi): unity at centre, full side at the stop
  wire signed [17:0] pan_gl = $signed(pan_cs[35:18]) - $signed(pan_cs[17:0]);
  wire signed [17:0] pan_gr = $signed(pan_cs[35:18]) + $signed(pan_cs[17:0]);
  wire signed [17:0] rc = $signed(spin_cs[35:18]);
  wire signed [17:0] rs = $signed(spin_cs[17:0]);
  wire signed [PW+17:0] pan_pl = pan_gl * eq_l_q;
  wire signed [PW+17:0] pan_pr = pan_gr * eq_r_q;
  // Plane rotation: same sum as balance for mono, orthogonal so power is kept
  wire signed [PW+17:0] rot_pl = (rc * pan_l_q) - (rs * pan_r_q);
  wire signed [PW+17:0] rot_pr = (rs * pan_l_q) + (rc * pan_r_q);
  wire signed [PW+20:0] mst_pl = $signed({1'b0, gain_q[0]}) * rot_l_q;
  wire signed [PW+20:0] mst_pr = $signed({1'b0, gain_q[0]}) * rot_r_q;

  always_ff @(posedge ref_clk) begin
    if (state_q == ST_EQ) begin
      eq_l_q <= eq_l_w;
      eq_r_q <= eq_r_w;
    end
    if (state_q == ST_PAN) begin
      pan_l_q <= PW'(pan_pl >>> 15);
      pan_r_q <= PW'(pan_pr >>> 15);
    end
    if (state_q == ST_ROT) begin
      rot_l_q <= PW'(rot_pl >>> 15);
      rot_r_q <= PW'(rot_pr >>> 15);
    end
  end
  // Output registers, pulse valid and status
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      out_valid <= 1'b0;
      out_left <= '0;
      out_right <= '0;
      in_ready <= 1'b0;
      pair_cnt_q <= 16'h0000;
      muted_q <= 1'b0;
    end else begin
      out_valid <= (state_q == ST_OUT);
      in_ready <= (state_d == ST_IDLE);
      if (state_q == ST_OUT) begin
        out_left <= sat_w(PW'(mst_pl >>> 16));
        out_right <= sat_w(PW'(mst_pr >>> 16));
        pair_cnt_q <= pair_cnt_q + 16'h0001;
        muted_q <= m_mute;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (take_pair) state_d = ST_GLOAD;
      end
      ST_GLOAD: state_d = ST_GMUL;
      ST_GMUL: begin
        if (gain_done) state_d = (gi_q == 2'd3) ? ST_FILT : ST_GLOAD;
      end
      ST_FILT: state_d = ST_EQ;
      ST_EQ: state_d = ST_PAN;
      ST_PAN: state_d = ST_ROT;
      ST_ROT: state_d = ST_OUT;
      ST_OUT: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end
  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;
endmodule

// ---- sim/slei_core_sva.sv ----
// Port checker for the level, EQ and image stage
module slei_chk
  import slei_pkg::*;
#(
  parameter int SAMPLE_W = 24
) (
  input wire logic ref_clk, // Clock
  input wire logic srst, // Sync reset
  input wire logic [5:0] avs_address, // Address
  input wire logic avs_read, // Read
  input wire logic avs_write, // Write
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [31:0] avs_readdata, // Read data
  input wire logic avs_waitrequest, // Stall
  input wire logic in_valid, // Pair offered
  input wire logic in_ready, // Pair taken
  input wire logic out_valid, // Result pulse
  input wire logic signed [SAMPLE_W-1:0] out_left, // Left result
  input wire logic signed [SAMPLE_W-1:0] out_right // Right result
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Mute tracking
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  // Frozen at take, so a later write cannot leak into a pair in flight
  wire mst_wr = avs_write && !avs_waitrequest && avs_address == REG_MASTER;
  wire take = in_valid && in_ready;
  logic mute_q;
  logic snap_q;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mute_q <= 1'b0;
      snap_q <= 1'b0;
    end else begin
      if (mst_wr)
        mute_q <= avs_writedata[7:0] >= MASTER_MUTE;
      if (take)
        snap_q <= mute_q;
    end
  end
  a_wait_one: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > REG_STATUS
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  a_take_drop: assert property (take |=> !in_ready)
    else $error("ready high after take");
  a_latency_win: assert property (take |=> (!out_valid && !in_ready) [*8]
    ##[1:200] out_valid) else $error("result out of window");
  a_pulse_one: assert property (out_valid |=> !out_valid)
    else $error("result pulse too long");
  a_ready_back: assert property (out_valid |-> in_ready)
    else $error("ready not back with result");
  a_out_hold: assert property (!out_valid |-> $stable(out_left) && $stable(out_right))
    else $error("result changed without pulse");
  a_mute_zero: assert property (out_valid && snap_q |-> out_left == '0 && out_right == '0)
    else $error("muted output not zero");
endmodule

bind slei_core slei_chk #(.SAMPLE_W(SAMPLE_W)) u_chk (
  .ref_clk(ref_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .in_valid(in_valid), .in_ready(in_ready),
  .out_valid(out_valid), .out_left(out_left), .out_right(out_right)
);

// ---- sim/slei_src.sv ----
// Upstream sample source feeding the stage
module slei_src (
  input wire logic ref_clk, // Stage clock
  input wire logic in_ready, // Stage can take a pair
  output logic in_valid, // Pair offered
  output logic signed [23:0] in_left, // Left sample
  output logic signed [23:0] in_right // Right sample
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Offer and hold
  // ----------------------------------------------------------------
  initial begin
    in_valid = 1'b0;
    in_left = '0;
    in_right = '0;
  end
  // Held until taken; afterwards the lines carry junk, never the old pair
  task automatic send(input logic signed [23:0] l, r, input int stall);
    repeat (stall + 1) @(posedge ref_clk);
    in_valid <= 1'b1;
    in_left <= l;
    in_right <= r;
    do @(posedge ref_clk); while (in_ready !== 1'b1);
    in_valid <= 1'b0;
    in_left <= ~l;
    in_right <= ~r;
  endtask
endmodule

// ---- sim/slei_core_bench.sv ----
// Self-checking bench for the level, EQ and image stage
module slei_core_bench import slei_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {real l; real r; bit c;} slei_exp_s;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [5:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata, rd_q;
  logic avs_waitrequest, in_valid, in_ready, out_valid;
  logic signed [23:0] in_left, in_right, out_left, out_right;
  logic [31:0] seed = 32'h201f;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  slei_exp_s exp_q[$];
  // ----------------------------------------------------------------
  // Clock, parts and helpers
  // ----------------------------------------------------------------
  always #4 ref_clk = ~ref_clk;
  slei_core dut (.ref_clk(ref_clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .in_valid(in_valid),
    .in_left(in_left), .in_right(in_right), .in_ready(in_ready), .out_valid(out_valid),
    .out_left(out_left), .out_right(out_right));
  slei_src u_src (.ref_clk(ref_clk), .in_ready(in_ready), .in_valid(in_valid),
    .in_left(in_left), .in_right(in_right));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string w, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask
  // Gains come from repeated multiplies, so a small relative slack is allowed
  task automatic chk_s(input string w, input real e, input logic signed [23:0] g);
    real t;
    t = (e < 0.0 ? -e : e) / 128.0 + 16.0;
    total_checks++;
    if (^g === 1'bx || real'(g) - e > t || e - real'(g) > t) begin
      errors++;
      $display("Error %s expected %0f seen %0d", w, e, g);
    end
  endtask
  // Holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd_q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rd_q);
  endtask
  // md[0] alternates sign, md[1] silences the left input
  task automatic run(input logic [7:0] m, p, ls, sp, lh, sn, input logic [1:0] md,
    input real gl, gr);
    logic signed [23:0] x;
    bus(1'b1, REG_MASTER, {24'h0, m});
    bus(1'b1, REG_PAN, {24'h0, p});
    bus(1'b1, REG_LOW_SHELF, {24'h0, ls});
    bus(1'b1, REG_SPATIAL, {24'h0, sp});
    bus(1'b1, REG_LEFT_HS, {24'h0, lh});
    bus(1'b1, REG_SPIN, {24'h0, sn});
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      x = {6'h01, seed[17:0]};
      if (md[0] && i[0])
        x = -x;
      exp_q.push_back('{real'(x) * gl, real'(x) * gr, i == 3});
      u_src.send(md[1] ? 24'sh0 : x, x, int'(seed[19:18]));
    end
    while (exp_q.size() != 0) @(posedge ref_clk);
    $display("Test done master %h pan %h shelf %h spatial %h spin %h", m, p, ls, sp, sn);
  endtask
  // Result watcher: oldest note against each pulse
  always @(posedge ref_clk) begin
    slei_exp_s e;
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors++;
      end_sim();
    end
    if (out_valid === 1'b1) begin
      chk("pair pending", 32'h1, 32'(exp_q.size() != 0));
      e = (exp_q.size() != 0) ? exp_q.pop_front() : slei_exp_s'{0.0, 0.0, 1'b0};
      if (e.c) begin
        chk_s("out_left", e.l, out_left);
        chk_s("out_right", e.r, out_right);
      end
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    rd(REG_MASTER, 32'h30);
    rd(REG_LOW_SHELF, 32'h0c);
    rd(REG_LOW_XO, 32'h1000);
    rd(REG_RIGHT_HS, 32'h0c);
    bus(1'b1, 6'h28, 32'h55);
    rd(6'h28, 32'h0);
    bus(1'b1, REG_PAN, 32'hfffffff8);
    rd(REG_PAN, 32'hf8);
    bus(1'b1, REG_LOW_XO, 32'hffff);
    run(8'h30, 8'h00, 8'h0c, 8'h00, 8'h0c, 8'h00, 2'd0, 1.0, 1.0);
    run(8'h00, 8'h00, 8'h0c, 8'h00, 8'h0c, 8'h00, 2'd0, 3.981072, 3.981072);
    run(8'h48, 8'h00, 8'h0c, 8'h00, 8'h0c, 8'h00, 2'd0, 0.501187, 0.501187);
    run(8'h78, 8'h00, 8'h0c, 8'h00, 8'h0c, 8'h00, 2'd0, 0.063096, 0.063096);
    run(8'hc1, 8'h00, 8'h0c, 8'h00, 8'h0c, 8'h00, 2'd0, 0.000794, 0.000794);
    run(8'hc6, 8'h00, 8'h0c, 8'h00, 8'h0c, 8'h00, 2'd0, 0.0, 0.0);
    rd(REG_STATUS, 32'h00020018);
    run(8'h30, 8'h08, 8'h0c, 8'h00, 8'h0c, 8'h00, 2'd0, 0.541196, 1.306563);
    run(8'h30, 8'h00, 8'h0c, 8'h00, 8'h0c, 8'h08, 2'd0, 0.541196, 1.306563);
    run(8'h30, 8'h00, 8'h0c, 8'h00, 8'h0c, 8'hf8, 2'd0, 1.306563, 0.541196);
    run(8'h30, 8'h00, 8'h0c, 8'h00, 8'h0c, 8'h08, 2'd2, -0.382683, 0.923880);
    run(8'h30, 8'h00, 8'h0c, 8'h18, 8'h0c, 8'h00, 2'd0, 0.0, 0.0);
    run(8'h30, 8'h00, 8'h0c, 8'he8, 8'h0c, 8'h00, 2'd0, 2.0, 2.0);
    run(8'h30, 8'h00, 8'h30, 8'h00, 8'h0c, 8'h00, 2'd0, 0.125893, 0.125893);
    run(8'h30, 8'h00, 8'h18, 8'h00, 8'h0c, 8'h00, 2'd0, 0.501187, 0.501187);
    srst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    rd(REG_MASTER, 32'h30);
    rd(REG_HIGH_XO, 32'h1000);
    bus(1'b1, REG_HIGH_XO, 32'h1);
    run(8'h30, 8'h00, 8'h0c, 8'h00, 8'h30, 8'h00, 2'd1, 0.125893, 1.0);
    end_sim();
  end
endmodule
